// ==== common/ioc_pkg.sv ====
// Types for the internal oscillator control block
package ioc_pkg;

   typedef enum logic [1:0] {
      IOC_SRC_HF,
      IOC_SRC_MF,
      IOC_SRC_LF
   } ioc_src_t;

   typedef struct packed {
      ioc_src_t   src;
      logic [3:0] div_log2;
   } ioc_route_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ioc_bus_req_t;

   typedef struct packed {
      logic por;
      logic brown;
      logic lp_brown;
      logic ext_clear;
      logic wdog;
      logic rst_instr;
      logic stk_ovf;
      logic stk_unf;
      logic prog_exit;
   } ioc_rst_src_t;

   typedef enum {
      IOC_SW_IDLE,
      IOC_SW_BUSY
   } ioc_sw_state_t;

endpackage

// ==== common/ioc_regs.svh ====
// Register offsets, field positions, reset values and timing counts for oscillator control
`ifndef IOC_REGS_SVH
`define IOC_REGS_SVH

// Register offsets (word index on the plain port)
`define IOC_ADDR_CTRL        4'h0
`define IOC_ADDR_TRIM        4'h1
`define IOC_ADDR_STAT        4'h2
`define IOC_ADDR_RST         4'h3

// Control register fields
`define IOC_CTRL_CLKSRC_LSB  0
`define IOC_CTRL_FSEL_LSB    3
`define IOC_CTRL_RST_VAL     8'h38

// Frequency select codes with fixed meaning
`define IOC_FSEL_RESET       4'h7
`define IOC_FSEL_LF          4'h0

// Reset-control register: bit 0 enables the power-up timer
`define IOC_RST_PUT_EN_BIT   0
`define IOC_RST_RST_VAL      8'h00

// Trim width and reset value
`define IOC_TRIM_W           6
`define IOC_TRIM_RST_VAL     6'h00

// Source switch settle times in ns, same source is short
`define IOC_SWITCH_SAME_NS   64
`define IOC_SWITCH_CROSS_NS  256
`define IOC_CLK_NS           8
`define IOC_SWITCH_SAME_CYC  ((`IOC_SWITCH_SAME_NS + `IOC_CLK_NS - 1) / `IOC_CLK_NS)
`define IOC_SWITCH_CROSS_CYC ((`IOC_SWITCH_CROSS_NS + `IOC_CLK_NS - 1) / `IOC_CLK_NS)

// Power-up timer extension, 64 ms nominal
`define IOC_PUT_MS           64
`define IOC_PUT_CYC          (`IOC_PUT_MS * 125000)

`endif

// ==== rtl/ioc_osc_ctrl.sv ====
// Internal oscillator selection, trim and enable logic
`timescale 1ns/1ps
`include "ioc_regs.svh"

// What this block does
// - Trim is a six-bit two's complement value, zero after reset.
// - Code 1fh trims highest, code 20h trims lowest frequency.
// - Trim change goes to both high and mid frequency sources.
// - Trim applies gradually, code runs on, no done flag exists.
// - Low frequency oscillator ignores trim entirely.
// - Low oscillator on for select 0000 with source 1x, config 00, or demand.
// - Watchdog and clock monitor run off low oscillator; power-up timer counts mclk_i cycles.
// - Status bit reads set while low oscillator runs.
// - Peripheral RC clock starts on any peripheral request.
// - Peripheral RC clock keeps running in sleep.
// - Four-bit select routes a postscaled source to system clock.
// - Any reset loads select with 0111, meaning 500 kHz.
// - Duplicate codes exist; same-source changes settle faster.
// - Listed reset events all force device reset.
// - Enabled power-up timer extends reset after power-on or brown-out.
module ioc_osc_ctrl
   import ioc_pkg::*;
#(
   parameter int unsigned PUT_CYC = `IOC_PUT_CYC
)(
   input  wire logic         mclk_i,
   input  wire logic         rst_n_i,
   input  wire ioc_bus_req_t bus_i,
   output logic [7:0]        rdata_o,
   input  wire logic [1:0]   cfg_osc_sel_i,
   input  wire logic         lf_demand_i,
   input  wire logic         lf_running_i,
   input  wire logic         rc_req_i,
   input  wire logic         sleep_i,
   input  wire ioc_rst_src_t rst_src_i,
   output logic [5:0]        hf_trim_o,
   output logic [5:0]        mf_trim_o,
   output logic              hf_en_o,
   output logic              mf_en_o,
   output logic              lf_en_o,
   output logic              lf_for_timers_o,
   output logic              rc_en_o,
   output ioc_route_t        route_o,
   output logic              switch_busy_o,
   output logic              sys_rst_o
);

   typedef struct packed {
      logic [1:0]    clk_src;
      logic [3:0]    fsel;
      logic [5:0]    trim;
      logic          put_en;
      logic [7:0]    rdata;
      logic          lf_s1;
      logic          lf_s2;
      logic          rc_s1;
      logic          rc_s2;
      logic          dem_s1;
      logic          dem_s2;
      ioc_route_t    route;
      ioc_sw_state_t sw;
      logic [7:0]    sw_cnt;
      logic          lf_en;
      logic          rc_en;
   } ioc_state_t;

   ioc_state_t st_reg;
   ioc_state_t st_next;
   logic       core_rst;
   ioc_route_t new_route;
   logic       lf_need;

   // Fixed select table; code 0111 duplicates the mid-source rate of code 0101
   function automatic ioc_route_t fsel_decode(input logic [3:0] code);
      ioc_route_t r;
      r.src      = IOC_SRC_MF;
      r.div_log2 = 4'h0;
      case (code)
         4'h0: begin r.src = IOC_SRC_LF; r.div_log2 = 4'h0; end
         4'h1: begin r.src = IOC_SRC_MF; r.div_log2 = 4'h4; end
         4'h2: begin r.src = IOC_SRC_MF; r.div_log2 = 4'h3; end
         4'h3: begin r.src = IOC_SRC_MF; r.div_log2 = 4'h2; end
         4'h4: begin r.src = IOC_SRC_MF; r.div_log2 = 4'h1; end
         4'h5: begin r.src = IOC_SRC_MF; r.div_log2 = 4'h0; end
         4'h6: begin r.src = IOC_SRC_HF; r.div_log2 = 4'h4; end
         4'h7: begin r.src = IOC_SRC_MF; r.div_log2 = 4'h0; end
         4'h8: begin r.src = IOC_SRC_HF; r.div_log2 = 4'h8; end
         4'h9: begin r.src = IOC_SRC_HF; r.div_log2 = 4'h7; end
         4'ha: begin r.src = IOC_SRC_HF; r.div_log2 = 4'h6; end
         4'hb: begin r.src = IOC_SRC_HF; r.div_log2 = 4'h5; end
         4'hc: begin r.src = IOC_SRC_HF; r.div_log2 = 4'h3; end
         4'hd: begin r.src = IOC_SRC_HF; r.div_log2 = 4'h2; end
         4'he: begin r.src = IOC_SRC_HF; r.div_log2 = 4'h1; end
         4'hf: begin r.src = IOC_SRC_HF; r.div_log2 = 4'h0; end
         default: begin r.src = IOC_SRC_MF; r.div_log2 = 4'h0; end
      endcase
      return r;
   endfunction

   // Reset collector and power-up timer
   ioc_reset_ctrl #(
      .PUT_CYC (PUT_CYC)
   ) u_rst (
      .mclk_i     (mclk_i),
      .rst_n_i    (rst_n_i),
      .src_i      (rst_src_i),
      .put_en_i   (st_reg.put_en),
      .sys_rst_o  (sys_rst_o),
      .put_busy_o ()
   );

   // Control reset covers every reset source, not only the port
   assign core_rst = !rst_n_i || sys_rst_o;

   // Next-state logic
   always_comb begin
      st_next   = st_reg;
      new_route = fsel_decode(st_reg.fsel);
      // Pin-level inputs pass two flops before use
      st_next.lf_s1  = lf_running_i;
      st_next.lf_s2  = st_reg.lf_s1;
      st_next.rc_s1  = rc_req_i;
      st_next.rc_s2  = st_reg.rc_s1;
      st_next.dem_s1 = lf_demand_i;
      st_next.dem_s2 = st_reg.dem_s1;

      // Register writes
      if (bus_i.wr) begin
         case (bus_i.addr)
            `IOC_ADDR_CTRL: begin
               st_next.clk_src = bus_i.wdata[`IOC_CTRL_CLKSRC_LSB +: 2];
               st_next.fsel = bus_i.wdata[`IOC_CTRL_FSEL_LSB +: 4];
            end
            `IOC_ADDR_TRIM: begin
               st_next.trim = bus_i.wdata[`IOC_TRIM_W-1:0];
            end
            `IOC_ADDR_RST: begin
               st_next.put_en = bus_i.wdata[`IOC_RST_PUT_EN_BIT];
            end
            default: begin
            end
         endcase
      end

      // Read data one cycle later; unmapped reads give zero
      st_next.rdata = 8'h00;
      if (bus_i.rd) begin
         case (bus_i.addr)
            `IOC_ADDR_CTRL: st_next.rdata = {1'b0, st_reg.fsel, 1'b0, st_reg.clk_src};
            `IOC_ADDR_TRIM: st_next.rdata = {2'b00, st_reg.trim};
            `IOC_ADDR_STAT: st_next.rdata = {6'h00, st_reg.sw == IOC_SW_BUSY,
                                             st_reg.lf_s2};
            `IOC_ADDR_RST:  st_next.rdata = {7'h00, st_reg.put_en};
            default:        st_next.rdata = 8'h00;
         endcase
      end

      // Switch timing: same source is quicker than a source change
      case (st_reg.sw)
         IOC_SW_IDLE: begin
            if (new_route != st_reg.route) begin
               st_next.sw = IOC_SW_BUSY;
               if (new_route.src == st_reg.route.src) begin
                  st_next.sw_cnt = 8'(`IOC_SWITCH_SAME_CYC);
               end else begin
                  st_next.sw_cnt = 8'(`IOC_SWITCH_CROSS_CYC);
               end
            end
         end
         IOC_SW_BUSY: begin
            if (st_reg.sw_cnt <= 8'h01) begin
               st_next.sw     = IOC_SW_IDLE;
               st_next.sw_cnt = 8'h00;
               st_next.route  = new_route;
            end else begin
               st_next.sw_cnt = st_reg.sw_cnt - 8'h01;
            end
         end
         default: begin
            st_next.sw = IOC_SW_IDLE;
         end
      endcase

      // Low oscillator enable conditions
      lf_need = (st_reg.fsel == `IOC_FSEL_LF && st_reg.clk_src[1])
                || cfg_osc_sel_i == 2'b00
                || st_reg.dem_s2;
      st_next.lf_en = lf_need;

      // RC clock follows requests only; sleep does not stop it
      st_next.rc_en = st_reg.rc_s2;
   end

   // State register; reset loads 500 kHz selection
   always_ff @(posedge mclk_i) begin
      if (core_rst) begin
         st_reg        <= '0;
         st_reg.fsel   <= `IOC_FSEL_RESET;
         st_reg.clk_src <= 2'b00;
         st_reg.trim   <= `IOC_TRIM_RST_VAL;
         st_reg.route  <= '{IOC_SRC_MF, 4'h0};
         st_reg.sw     <= IOC_SW_IDLE;
         st_reg.put_en <= (!rst_n_i) ? 1'b0 : st_reg.put_en;
      end else begin
         st_reg <= st_next;
      end
   end

   // Trim goes to both calibrated sources, raw signed code; no done flag
   assign hf_trim_o = st_reg.trim;
   assign mf_trim_o = st_reg.trim;
   // 1fh is top of the signed range, 20h bottom
   assign hf_en_o   = (st_reg.route.src == IOC_SRC_HF);
   assign mf_en_o   = (st_reg.route.src == IOC_SRC_MF);
   // Low oscillator has no trim input at all
   assign lf_en_o         = st_reg.lf_en;
   assign lf_for_timers_o = st_reg.lf_en;
   assign rc_en_o         = st_reg.rc_en;
   assign route_o         = st_reg.route;
   assign switch_busy_o   = (st_reg.sw == IOC_SW_BUSY);
   assign rdata_o         = st_reg.rdata;

endmodule

// ==== rtl/ioc_reset_ctrl.sv ====
// Reset request collector with optional power-up timer extension
`timescale 1ns/1ps
`include "ioc_regs.svh"

module ioc_reset_ctrl
   import ioc_pkg::*;
#(
   parameter int unsigned PUT_CYC = `IOC_PUT_CYC
)(
   input  wire logic         mclk_i,
   input  wire logic         rst_n_i,
   input  wire ioc_rst_src_t src_i,
   input  wire logic         put_en_i,
   output logic              sys_rst_o,
   output logic              put_busy_o
);

   typedef struct packed {
      logic        sys_rst;
      logic        busy;
      logic [23:0] cnt;
   } ioc_rc_state_t;

   ioc_rc_state_t st_reg;
   ioc_rc_state_t st_next;
   logic          any_evt;
   logic          supply_evt;

   // Any source resets; supply events also start the timer
   always_comb begin
      any_evt    = |src_i;
      supply_evt = src_i.por | src_i.brown;
      st_next    = st_reg;
      st_next.sys_rst = any_evt;
      if (supply_evt && put_en_i) begin
         st_next.busy = 1'b1;
         st_next.cnt  = 24'(PUT_CYC);
      end else if (st_reg.busy) begin
         if (st_reg.cnt <= 24'h000001) begin
            st_next.busy = 1'b0;
            st_next.cnt  = 24'h000000;
         end else begin
            st_next.cnt = st_reg.cnt - 24'h000001;
         end
      end
      if (st_next.busy) begin
         st_next.sys_rst = 1'b1;
      end
   end

   // State register
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sys_rst_o  = st_reg.sys_rst;
   assign put_busy_o = st_reg.busy;

endmodule

// ==== testbench/ioc_osc_ctrl_properties.sv ====
// Port-level assertions for the oscillator control block
`timescale 1ns/1ps
`include "ioc_regs.svh"
module ioc_osc_chk
   import ioc_pkg::*;
#(
   parameter int unsigned PUT_CYC = `IOC_PUT_CYC
)(
   input wire logic         mclk_i,
   input wire logic         rst_n_i,
   input wire ioc_bus_req_t bus_i,
   input wire logic [7:0]   rdata_o,
   input wire logic [1:0]   cfg_osc_sel_i,
   input wire logic         lf_demand_i,
   input wire logic         lf_running_i,
   input wire logic         rc_req_i,
   input wire logic         sleep_i,
   input wire ioc_rst_src_t rst_src_i,
   input wire logic [5:0]   hf_trim_o,
   input wire logic [5:0]   mf_trim_o,
   input wire logic         hf_en_o,
   input wire logic         mf_en_o,
   input wire logic         lf_en_o,
   input wire logic         lf_for_timers_o,
   input wire logic         rc_en_o,
   input wire ioc_route_t   route_o,
   input wire logic         switch_busy_o,
   input wire logic         sys_rst_o
);
   logic sys_rst_d_reg;
   // Control state reloads one cycle after the reset flag, so mask that cycle too
   always_ff @(posedge mclk_i) sys_rst_d_reg <= sys_rst_o;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_sw_start;
      $rose(switch_busy_o);
   endsequence
   sequence s_stat_read;
      bus_i.rd && bus_i.addr == `IOC_ADDR_STAT;
   endsequence
   AST_TRIM_SHARED: assert property (hf_trim_o == mf_trim_o)
      else $error("trim outputs differ");
   AST_TRIM_LOAD: assert property (
      bus_i.wr && bus_i.addr == `IOC_ADDR_TRIM && !sys_rst_o && rst_src_i == '0
      |=> hf_trim_o == $past(bus_i.wdata[5:0])) else $error("trim not loaded");
   AST_STAT_READ: assert property (($stable(lf_running_i))[*4] ##0 s_stat_read
      |=> rdata_o == {6'h00, $past(switch_busy_o), $past(lf_running_i)})
      else $error("status read wrong");
   AST_LF_CFG: assert property ((cfg_osc_sel_i == 2'b00)[*2] |-> lf_en_o)
      else $error("low osc off with config 00");
   AST_RC_ON: assert property (rc_req_i[*4] |-> rc_en_o)
      else $error("rc clock not started");
   AST_RC_OFF: assert property ((!rc_req_i)[*4] |-> !rc_en_o)
      else $error("rc clock runs unrequested");
   AST_SW_BOUND: assert property (@(posedge mclk_i) disable iff (!rst_n_i || sys_rst_o)
      s_sw_start |-> ##[1:40] !switch_busy_o) else $error("switch never settles");
   AST_ROUTE_HOLD: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i || sys_rst_o || sys_rst_d_reg)
      $changed(route_o) |-> $past(switch_busy_o) || $past(switch_busy_o, 2))
      else $error("route changed outside a switch");
   AST_SRC_RST: assert property (rst_src_i != '0 |=> sys_rst_o)
      else $error("reset event ignored");
   AST_RST_DEFAULT: assert property ($fell(sys_rst_o) |->
      route_o == ioc_route_t'{IOC_SRC_MF, 4'h0} && hf_trim_o == 6'h00)
      else $error("defaults not restored");
endmodule

bind ioc_osc_ctrl ioc_osc_chk #(.PUT_CYC(PUT_CYC)) u_chk (
   .mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
   .cfg_osc_sel_i(cfg_osc_sel_i), .lf_demand_i(lf_demand_i), .lf_running_i(lf_running_i),
   .rc_req_i(rc_req_i), .sleep_i(sleep_i), .rst_src_i(rst_src_i), .hf_trim_o(hf_trim_o),
   .mf_trim_o(mf_trim_o), .hf_en_o(hf_en_o), .mf_en_o(mf_en_o), .lf_en_o(lf_en_o),
   .lf_for_timers_o(lf_for_timers_o), .rc_en_o(rc_en_o), .route_o(route_o),
   .switch_busy_o(switch_busy_o), .sys_rst_o(sys_rst_o));

// ==== testbench/tb.sv ====
// Self-checking bench for the oscillator control block
`timescale 1ns/1ps
`include "ioc_regs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb;
   import ioc_pkg::*;
   localparam int unsigned PUT_CYC = 20;
   localparam logic [5:0] TV[3] = '{6'h1f, 6'h20, 6'h00};
   logic         mclk_i, rst_n_i, lf_demand_i, lf_running_i, rc_req_i, sleep_i;
   logic         hf_en_o, mf_en_o, lf_en_o, lf_for_timers_o, rc_en_o, switch_busy_o;
   logic         sys_rst_o;
   logic [1:0]   cfg_osc_sel_i;
   logic [5:0]   hf_trim_o, mf_trim_o;
   logic [7:0]   rdata_o;
   ioc_bus_req_t bus_i;
   ioc_rst_src_t rst_src_i;
   ioc_route_t   route_o, er;
   ioc_src_t     prev;
   int           err_total, checks, n, same_max, cross_min;

   ioc_osc_ctrl #(.PUT_CYC(PUT_CYC)) dut (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
      .cfg_osc_sel_i(cfg_osc_sel_i), .lf_demand_i(lf_demand_i), .lf_running_i(lf_running_i),
      .rc_req_i(rc_req_i), .sleep_i(sleep_i), .rst_src_i(rst_src_i), .hf_trim_o(hf_trim_o),
      .mf_trim_o(mf_trim_o), .hf_en_o(hf_en_o), .mf_en_o(mf_en_o), .lf_en_o(lf_en_o),
      .lf_for_timers_o(lf_for_timers_o), .rc_en_o(rc_en_o), .route_o(route_o),
      .switch_busy_o(switch_busy_o), .sys_rst_o(sys_rst_o));

   // 125 MHz clock
   initial begin
      mclk_i = 1'b0;
      forever #4 mclk_i = ~mclk_i;
   end

   task automatic test_done();
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic hang();
      err_total++;
      $display("[FAIL] %0t wait limit reached", $time);
      test_done();
   endtask

   // Step k edges, then let the edge's updates land before sampling
   task automatic cyc(input int k);
      repeat (k) @(posedge mclk_i);
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      bus_i <= '{a, d, 1'b1, 1'b0};
      @(posedge mclk_i);
      bus_i.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge mclk_i);
      bus_i <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge mclk_i);
      bus_i.rd <= 1'b0;
      #1;
      `CHK(rdata_o, e);
   endtask

   // Waits for a possible switch; n ends as the busy length
   task automatic settle();
      for (n = 0; n < 4 && !switch_busy_o; n++) cyc(1);
      for (n = 0; n < 60 && switch_busy_o; n++) cyc(1);
      if (n >= 60) hang();
   endtask

   // Select code table chosen for this block
   function automatic ioc_route_t exp_route(input logic [3:0] f);
      if (f == 4'h0) return '{IOC_SRC_LF, 4'h0};
      if (f <= 4'h5) return '{IOC_SRC_MF, 4'h5 - f};
      if (f == 4'h6) return '{IOC_SRC_HF, 4'h4};
      if (f == 4'h7) return '{IOC_SRC_MF, 4'h0};
      if (f <= 4'hb) return '{IOC_SRC_HF, 4'h0 - f};
      return '{IOC_SRC_HF, 4'hf - f};
   endfunction

   // Hard limit on run length
   initial begin
      repeat (100000) @(posedge mclk_i);
      hang();
   end

   initial begin
      rst_n_i = 1'b0;
      bus_i = '0;
      rst_src_i = '0;
      cfg_osc_sel_i = 2'b01;
      lf_demand_i = 1'b0;
      lf_running_i = 1'b1;
      rc_req_i = 1'b0;
      sleep_i = 1'b0;
      prev = IOC_SRC_MF;
      same_max = 0;
      cross_min = 1000;
      repeat (8) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      cyc(3);
      rd(`IOC_ADDR_CTRL, `IOC_CTRL_RST_VAL);
      `CHK(route_o, exp_route(4'h7));
      rd(`IOC_ADDR_STAT, 8'h01);
      rd(4'h9, 8'h00);
      // Trim extremes reach both sources and raise no flag
      for (int i = 0; i < 3; i++) begin
         wr(`IOC_ADDR_TRIM, {2'b00, TV[i]});
         rd(`IOC_ADDR_TRIM, {2'b00, TV[i]});
         `CHK(hf_trim_o, TV[i]);
         `CHK(mf_trim_o, TV[i]);
         rd(`IOC_ADDR_STAT, 8'h01);
         `CHK(lf_en_o, 1'b0);
      end
      // Every select code, timing same-source against cross-source changes
      for (int f = 0; f < 16; f++) begin
         er = exp_route(f[3:0]);
         wr(`IOC_ADDR_CTRL, {1'b0, f[3:0], 3'b000});
         settle();
         if (er.src == prev && n > same_max) same_max = n;
         if (er.src != prev && n < cross_min) cross_min = n;
         `CHK(route_o, er);
         `CHK(hf_en_o, er.src == IOC_SRC_HF);
         `CHK(mf_en_o, er.src == IOC_SRC_MF);
         prev = er.src;
      end
      `CHK(same_max < cross_min, 1'b1);
      // Low oscillator enable causes
      wr(`IOC_ADDR_CTRL, 8'h02);
      settle();
      `CHK(lf_en_o, 1'b1);
      wr(`IOC_ADDR_CTRL, 8'h00);
      cyc(3);
      `CHK(lf_en_o, 1'b0);
      @(posedge mclk_i) lf_demand_i <= 1'b1;
      cyc(5);
      `CHK(lf_en_o, 1'b1);
      `CHK(lf_for_timers_o, 1'b1);
      @(posedge mclk_i);
      lf_demand_i <= 1'b0;
      cfg_osc_sel_i <= 2'b00;
      cyc(5);
      `CHK(lf_en_o, 1'b1);
      @(posedge mclk_i);
      cfg_osc_sel_i <= 2'b01;
      sleep_i <= 1'b1;
      rc_req_i <= 1'b1;
      cyc(5);
      `CHK(rc_en_o, 1'b1);
      @(posedge mclk_i) rc_req_i <= 1'b0;
      cyc(5);
      `CHK(rc_en_o, 1'b0);
      @(posedge mclk_i) lf_running_i <= 1'b0;
      cyc(4);
      rd(`IOC_ADDR_STAT, 8'h00);
      @(posedge mclk_i) lf_running_i <= 1'b1;
      // Each reset event, timer stretching only power-on and brown-out
      wr(`IOC_ADDR_RST, 8'h01);
      for (int i = 0; i < 9; i++) begin
         wr(`IOC_ADDR_TRIM, 8'h05);
         @(posedge mclk_i) rst_src_i <= ioc_rst_src_t'(9'h001 << i);
         @(posedge mclk_i) rst_src_i <= '0;
         #1;
         `CHK(sys_rst_o, 1'b1);
         for (n = 0; n < PUT_CYC + 10 && sys_rst_o; n++) cyc(1);
         if (n >= PUT_CYC + 10) hang();
         `CHK(n >= PUT_CYC, i >= 7);
         rd(`IOC_ADDR_TRIM, 8'h00);
         rd(`IOC_ADDR_CTRL, `IOC_CTRL_RST_VAL);
      end
      test_done();
   end
endmodule
